// ==== src/gsr_pkg.sv ====
// package: constants and types for the status reporting block
package gsr_pkg;
    localparam int unsigned       GSR_W           = 16;
    // standard event bit positions
    localparam int unsigned       GSR_QYE_BIT     = 2;
    // operation condition bit positions
    localparam int unsigned       GSR_TRIG_BIT    = 5;
    localparam int unsigned       GSR_ARM_BIT     = 6;
    localparam int unsigned       GSR_IDLE_BIT    = 10;
    // reset values
    localparam logic [15:0]       GSR_SEL_RST     = 16'h0000;
    localparam logic [15:0]       GSR_SEM_RST     = 16'h0000;
    localparam logic [15:0]       GSR_OPEV_RST    = 16'h0000;
    localparam logic [15:0]       GSR_OPEN_RST    = 16'h0000;
    localparam logic [15:0]       GSR_RISE_RST    = 16'hFFFF;
    localparam logic [15:0]       GSR_FALL_RST    = 16'h0000;

    // register select codes for the command port
    typedef enum logic [2:0] {
        GSR_REG_SEL  = 3'h0,
        GSR_REG_SEM  = 3'h1,
        GSR_REG_COND = 3'h2,
        GSR_REG_RISE = 3'h3,
        GSR_REG_FALL = 3'h4,
        GSR_REG_OPEV = 3'h5,
        GSR_REG_OPEN = 3'h6
    } gsr_reg_t;

    // one status command from the bus parser
    typedef struct packed {
        logic        wr;
        logic        rd;
        gsr_reg_t    sel;
        logic [15:0] data;
    } gsr_cmd_t;

    // bus interface addressing events, one-cycle pulses
    typedef struct packed {
        logic mta;
        logic mla;
        logic unt;
        logic unl;
        logic ifc;
        logic llo;
        logic gtl;
    } gsr_bus_ev_t;

    // interface state machine, Gray along local->remote->lockout
    typedef enum logic [1:0] {
        GSR_LOCAL   = 2'b00,
        GSR_REMOTE  = 2'b01,
        GSR_LOCKOUT = 2'b11
    } gsr_rem_t;
endpackage : gsr_pkg

// ==== src/gsr_event_latch.sv ====
// module: transition filter and sticky event latch with clear-on-read
`timescale 1ns/1ps
`default_nettype none
module gsr_event_latch
    import gsr_pkg::*;
#(
    parameter int unsigned W = GSR_W
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] cond,
    input  wire logic [W-1:0] rise_en,
    input  wire logic [W-1:0] fall_en,
    input  wire logic         clr,
    output logic      [W-1:0] ev,
    output logic      [W-1:0] cond_q
);
    logic [W-1:0] ev_r,   ev_nxt;
    logic [W-1:0] prev_r, prev_nxt;
    logic [W-1:0] hit;

    always_comb begin
        prev_nxt = cond;
        hit      = (cond & ~prev_r & rise_en) | (~cond & prev_r & fall_en); // R14 R19
        ev_nxt   = (clr ? '0 : ev_r) | hit; // R16 R20
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ev_r   <= '0;
            prev_r <= '0;
        end else begin
            ev_r   <= ev_nxt;
            prev_r <= prev_nxt;
        end
    end

    assign ev     = ev_r;
    assign cond_q = prev_r;

    property p_ev_sets;
        @(posedge clk) disable iff (!rst_b)
        (|hit) |=> ((ev_r & $past(hit)) == $past(hit));
    endproperty
    a_ev_sets: assert property (p_ev_sets) else $error("filtered edge not latched"); // R19

    property p_ev_sticky;
        @(posedge clk) disable iff (!rst_b)
        !clr |=> ((ev_r & $past(ev_r)) == $past(ev_r));
    endproperty
    a_ev_sticky: assert property (p_ev_sticky) else $error("event bit dropped without clear"); // R16
endmodule : gsr_event_latch
`default_nettype wire

// ==== src/gsr_status.sv ====
// module: status reporting and interface state of the switch instrument
// What this block does
// (R01) remote state needs remote enable true and listen addressing together
// (R02) in remote, every front key except local is ignored
// (R03) talk address sets talker; untalk, listen address or clear idles it
// (R04) listen address sets listener; unlisten, talk address or clear idles it
// (R05) service request lamp stays lit until serial poll byte is read
// (R06) local key leaves remote unless local lockout is in effect
// (R07) local key also darkens remote lamp and restores normal display
// (R08) standard events latch until cleared; empty queue read sets bit 2
// (R09) standard event read returns and clears; clear-status and power-up clear
// (R10) event summary is OR of standard events ANDed with mask
// (R11) mask read leaves it; cleared only by power-up or writing zero
// (R12) 16-bit live operation condition; bit 10 shows idle
// (R13) condition bit 5 waits in trigger, bit 6 waits in arm
// (R14) event sets on rising edge if rise filter, falling if fall filter
// (R15) both 16-bit filters writable and readable at any time
// (R16) operation events latch; cleared by read, clear-status, power-up
// (R17) power-up or preset: rise filter all ones, fall filter zero
// (R18) operation summary is OR of events ANDed with enable
// (R19) edges are found against the previous clock's condition
// (R20) new event wins over same-cycle clear-on-read
`timescale 1ns/1ps
`default_nettype none
module gsr_status
    import gsr_pkg::*;
#(
    parameter int unsigned W = GSR_W
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire gsr_cmd_t     cmd,
    input  wire logic         cls,
    input  wire logic         preset,
    input  wire logic [W-1:0] std_event_in,
    input  wire logic         empty_queue_read,
    input  wire logic         idle,
    input  wire logic         wait_trig,
    input  wire logic         wait_arm,
    input  wire logic [W-1:0] other_cond,
    input  wire logic         remote_enable,
    input  wire gsr_bus_ev_t  bus_ev,
    input  wire logic         srq_gen,
    input  wire logic         spoll_read,
    input  wire logic         key_local,
    input  wire logic         key_any,
    output logic      [W-1:0] rd_data,
    output logic              esb,
    output logic              osb,
    output logic              remote_indicator,
    output logic              talk_indicator,
    output logic              listener_indicator,
    output logic              srq_indicator,
    output logic              key_accept,
    output logic              restore_display
);
    ////////////////////////////////////////////////////////////////////////
    logic [W-1:0] sel_r,  sel_nxt;
    logic [W-1:0] sem_r,  sem_nxt;
    logic [W-1:0] rise_r, rise_nxt;
    logic [W-1:0] fall_r, fall_nxt;
    logic [W-1:0] open_r, open_nxt;
    logic [W-1:0] rd_r,   rd_nxt;
    logic         esb_r,  esb_nxt;
    logic         osb_r,  osb_nxt;
    logic [W-1:0] op_cond;
    logic [W-1:0] op_ev;
    logic [W-1:0] op_cond_q;
    logic         op_clr;
    logic [W-1:0] std_set;

    function automatic logic wr_to(input gsr_cmd_t c, input gsr_reg_t r);
        wr_to = c.wr && (c.sel == r);
    endfunction : wr_to

    function automatic logic rd_of(input gsr_cmd_t c, input gsr_reg_t r);
        rd_of = c.rd && (c.sel == r);
    endfunction : rd_of

    // live condition word; other_cond fills the unassigned bits
    always_comb begin
        op_cond               = other_cond; // R12
        op_cond[GSR_IDLE_BIT] = idle; // R12
        op_cond[GSR_TRIG_BIT] = wait_trig; // R13
        op_cond[GSR_ARM_BIT]  = wait_arm; // R13
    end

    assign op_clr = cls || rd_of(cmd, GSR_REG_OPEV); // R16

    gsr_event_latch #(
        .W (W)
    ) u_op_latch (
        .clk     (clk),
        .rst_b   (rst_b),
        .cond    (op_cond),
        .rise_en (rise_r),
        .fall_en (fall_r),
        .clr     (op_clr),
        .ev      (op_ev),
        .cond_q  (op_cond_q)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        std_set               = std_event_in;
        std_set[GSR_QYE_BIT]  = std_event_in[GSR_QYE_BIT] | empty_queue_read; // R08
        // set beats the clear so a same-cycle event survives the read
        sel_nxt = ((cls || rd_of(cmd, GSR_REG_SEL)) ? '0 : sel_r) | std_set; // R08 R09 R20
        sem_nxt  = wr_to(cmd, GSR_REG_SEM)  ? cmd.data : sem_r; // R11
        open_nxt = wr_to(cmd, GSR_REG_OPEN) ? cmd.data : open_r;
        rise_nxt = wr_to(cmd, GSR_REG_RISE) ? cmd.data : rise_r; // R15
        fall_nxt = wr_to(cmd, GSR_REG_FALL) ? cmd.data : fall_r; // R15
        if (preset) begin
            rise_nxt = GSR_RISE_RST; // R17
            fall_nxt = GSR_FALL_RST; // R17
            open_nxt = GSR_OPEN_RST;
        end
        esb_nxt = |(sel_r & sem_r); // R10
        osb_nxt = |(op_ev & open_r); // R18
        rd_nxt  = rd_r;
        if (cmd.rd) begin
            unique case (cmd.sel)
                GSR_REG_SEL:  rd_nxt = sel_r; // R09
                GSR_REG_SEM:  rd_nxt = sem_r; // R11
                GSR_REG_COND: rd_nxt = op_cond_q;
                GSR_REG_RISE: rd_nxt = rise_r; // R15
                GSR_REG_FALL: rd_nxt = fall_r; // R15
                GSR_REG_OPEV: rd_nxt = op_ev; // R16
                GSR_REG_OPEN: rd_nxt = open_r;
                default:      rd_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_r  <= GSR_SEL_RST; // R09
            sem_r  <= GSR_SEM_RST; // R11
            rise_r <= GSR_RISE_RST; // R17
            fall_r <= GSR_FALL_RST; // R17
            open_r <= GSR_OPEN_RST;
            rd_r   <= '0;
            esb_r  <= 1'b0;
            osb_r  <= 1'b0;
        end else begin
            sel_r  <= sel_nxt;
            sem_r  <= sem_nxt;
            rise_r <= rise_nxt;
            fall_r <= fall_nxt;
            open_r <= open_nxt;
            rd_r   <= rd_nxt;
            esb_r  <= esb_nxt;
            osb_r  <= osb_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interface state: remote/lockout, talker, listener, service lamp
    gsr_rem_t rem_r, rem_nxt;
    logic     tlk_r, tlk_nxt;
    logic     lsn_r, lsn_nxt;
    logic     srq_r, srq_nxt;
    logic     ka_r,  ka_nxt;
    logic     rd_disp_r, rd_disp_nxt;
    logic     rem_ind_r, rem_ind_nxt;
    logic     local_go;

    // local key only counts in remote, not in local or lockout
    assign local_go = key_local && (rem_r == GSR_REMOTE); // R06

    always_comb begin
        rem_nxt = rem_r;
        if (!remote_enable) begin
            rem_nxt = GSR_LOCAL;
        end else begin
            unique case (rem_r)
                GSR_LOCAL: begin
                    if (bus_ev.mla) begin
                        rem_nxt = bus_ev.llo ? GSR_LOCKOUT : GSR_REMOTE; // R01
                    end
                end
                GSR_REMOTE: begin
                    if (bus_ev.gtl || local_go) begin
                        rem_nxt = GSR_LOCAL; // R06
                    end else if (bus_ev.llo) begin
                        rem_nxt = GSR_LOCKOUT;
                    end
                end
                GSR_LOCKOUT: begin
                    if (bus_ev.gtl) begin
                        rem_nxt = GSR_LOCAL; // R06
                    end
                end
                default: rem_nxt = GSR_LOCAL;
            endcase
        end
        // listen addressing drops talk and vice versa
        tlk_nxt = tlk_r;
        if (bus_ev.ifc || bus_ev.unt || bus_ev.mla) begin
            tlk_nxt = 1'b0; // R03
        end else if (bus_ev.mta) begin
            tlk_nxt = 1'b1; // R03
        end
        lsn_nxt = lsn_r;
        if (bus_ev.ifc || bus_ev.unl || bus_ev.mta) begin
            lsn_nxt = 1'b0; // R04
        end else if (bus_ev.mla) begin
            lsn_nxt = 1'b1; // R04
        end
        // a fresh request beats the poll read in the same cycle
        srq_nxt = srq_gen ? 1'b1 : (spoll_read ? 1'b0 : srq_r); // R05
        ka_nxt  = key_any && (rem_r == GSR_LOCAL); // R02
        rd_disp_nxt = local_go; // R07
        // registered so the lamp pin comes straight from a flop
        rem_ind_nxt = (rem_nxt != GSR_LOCAL); // R01 R07
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rem_r     <= GSR_LOCAL;
            tlk_r     <= 1'b0;
            lsn_r     <= 1'b0;
            srq_r     <= 1'b0;
            ka_r      <= 1'b0;
            rd_disp_r <= 1'b0;
            rem_ind_r <= 1'b0;
        end else begin
            rem_r     <= rem_nxt;
            tlk_r     <= tlk_nxt;
            lsn_r     <= lsn_nxt;
            srq_r     <= srq_nxt;
            ka_r      <= ka_nxt;
            rd_disp_r <= rd_disp_nxt;
            rem_ind_r <= rem_ind_nxt;
        end
    end

    assign rd_data            = rd_r;
    assign esb                = esb_r;
    assign osb                = osb_r;
    assign remote_indicator   = rem_ind_r; // R01 R07
    assign talk_indicator     = tlk_r;
    assign listener_indicator = lsn_r;
    assign srq_indicator      = srq_r;
    assign key_accept         = ka_r;
    assign restore_display    = rd_disp_r;

    ////////////////////////////////////////////////////////////////////////
    property p_rem_needs_mla;
        @(posedge clk) disable iff (!rst_b)
        (rem_r == GSR_LOCAL && rem_nxt != GSR_LOCAL) |-> (remote_enable && bus_ev.mla);
    endproperty
    a_rem_needs_mla: assert property (p_rem_needs_mla) else $error("remote without listen address"); // R01

    property p_keys_locked;
        @(posedge clk) disable iff (!rst_b)
        (key_any && rem_r != GSR_LOCAL) |=> !key_accept;
    endproperty
    a_keys_locked: assert property (p_keys_locked) else $error("key accepted in remote"); // R02

    property p_talk;
        @(posedge clk) disable iff (!rst_b)
        (bus_ev.mta && !bus_ev.ifc && !bus_ev.unt && !bus_ev.mla) |=> (talk_indicator && !listener_indicator);
    endproperty
    a_talk: assert property (p_talk) else $error("talk address not taken"); // R03

    property p_listen_clear;
        @(posedge clk) disable iff (!rst_b)
        (bus_ev.ifc || bus_ev.unl) |=> !listener_indicator;
    endproperty
    a_listen_clear: assert property (p_listen_clear) else $error("listener not idled"); // R04

    sequence s_srq_lit;
        srq_gen ##1 srq_indicator;
    endsequence
    property p_srq_hold;
        @(posedge clk) disable iff (!rst_b)
        s_srq_lit ##0 (!spoll_read && !srq_gen) |=> srq_indicator;
    endproperty
    a_srq_hold: assert property (p_srq_hold) else $error("service lamp dropped early"); // R05

    property p_lockout_key;
        @(posedge clk) disable iff (!rst_b)
        (rem_r == GSR_LOCKOUT && remote_enable && !bus_ev.gtl) |=> remote_indicator;
    endproperty
    a_lockout_key: assert property (p_lockout_key) else $error("lockout left by local key"); // R06

    property p_local_key;
        @(posedge clk) disable iff (!rst_b)
        local_go |=> (!remote_indicator && restore_display);
    endproperty
    a_local_key: assert property (p_local_key) else $error("local key ignored"); // R07

    property p_qye;
        @(posedge clk) disable iff (!rst_b)
        empty_queue_read |=> sel_r[GSR_QYE_BIT];
    endproperty
    a_qye: assert property (p_qye) else $error("query error not latched"); // R08

    property p_sel_read;
        @(posedge clk) disable iff (!rst_b)
        (rd_of(cmd, GSR_REG_SEL) && std_set == '0) |=> (sel_r == '0 && rd_data == $past(sel_r));
    endproperty
    a_sel_read: assert property (p_sel_read) else $error("event read did not clear"); // R09

    property p_esb;
        @(posedge clk) disable iff (!rst_b)
        1'b1 |=> (esb == |($past(sel_r) & $past(sem_r)));
    endproperty
    a_esb: assert property (p_esb) else $error("summary bit mismatch"); // R10

    property p_mask_keep;
        @(posedge clk) disable iff (!rst_b)
        !wr_to(cmd, GSR_REG_SEM) |=> $stable(sem_r);
    endproperty
    a_mask_keep: assert property (p_mask_keep) else $error("mask changed without write"); // R11

    property p_preset;
        @(posedge clk) disable iff (!rst_b)
        preset |=> (rise_r == GSR_RISE_RST && fall_r == GSR_FALL_RST);
    endproperty
    a_preset: assert property (p_preset) else $error("preset did not restore filters"); // R17

    property p_osb;
        @(posedge clk) disable iff (!rst_b)
        1'b1 |=> (osb == |($past(op_ev) & $past(open_r)));
    endproperty
    a_osb: assert property (p_osb) else $error("operation summary mismatch"); // R18
endmodule : gsr_status
`default_nettype wire

// ==== tb/gsr_ctrl_model.sv ====
// bus controller model: status commands, addressing events and remote enable
`timescale 1ns/1ps
`default_nettype none
module gsr_ctrl_model
    import gsr_pkg::*;
(
    input  wire logic      clk,
    output var gsr_cmd_t    cmd,
    output logic            cls,
    output logic            preset,
    output logic            remote_enable,
    output var gsr_bus_ev_t bus_ev,
    output logic            spoll_read
);
    initial begin
        cmd           = '0;
        cls           = 1'b0;
        preset        = 1'b0;
        remote_enable = 1'b0;
        bus_ev        = '0;
        spoll_read    = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // one command a call; rd_data lands on the edge that samples the command, then one quiet edge follows
    task automatic do_cmd(input logic w, input logic r, input gsr_reg_t s, input logic [15:0] d);
        @(posedge clk);
        cmd <= '{wr: w, rd: r, sel: s, data: d};
        @(posedge clk);
        cmd <= '0;
        @(posedge clk);
    endtask : do_cmd
    task automatic bus(input logic [6:0] e);
        @(posedge clk);
        bus_ev <= gsr_bus_ev_t'(e);
        @(posedge clk);
        bus_ev <= '0;
    endtask : bus
    // clear-status, preset and serial poll are all single pulses
    task automatic misc(input logic c, input logic p, input logic s);
        @(posedge clk);
        cls        <= c;
        preset     <= p;
        spoll_read <= s;
        @(posedge clk);
        cls        <= 1'b0;
        preset     <= 1'b0;
        spoll_read <= 1'b0;
    endtask : misc
    task automatic ren(input logic v);
        @(posedge clk);
        remote_enable <= v;
    endtask : ren
endmodule : gsr_ctrl_model
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the status reporting block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import gsr_pkg::*;
;
    logic clk, rst_b, empty_queue_read, idle, wait_trig, wait_arm, srq_gen, key_local, key_any;
    logic [15:0] std_event_in, other_cond, rd_data;
    logic [15:0] acc_cnt = 16'h0000, rst_cnt = 16'h0000;
    logic esb, osb, remote_indicator, talk_indicator, listener_indicator, srq_indicator;
    logic key_accept, restore_display, cls, preset, remote_enable, spoll_read;
    gsr_cmd_t    cmd;
    gsr_bus_ev_t bus_ev;
    int fail_count = 0, samples_checked = 0, cycles = 0;
    gsr_ctrl_model ctrl_inst (.clk(clk), .cmd(cmd), .cls(cls), .preset(preset),
        .remote_enable(remote_enable), .bus_ev(bus_ev), .spoll_read(spoll_read));
    gsr_status gsr_status_inst (.clk(clk), .rst_b(rst_b), .cmd(cmd), .cls(cls), .preset(preset),
        .std_event_in(std_event_in), .empty_queue_read(empty_queue_read), .idle(idle),
        .wait_trig(wait_trig), .wait_arm(wait_arm), .other_cond(other_cond),
        .remote_enable(remote_enable), .bus_ev(bus_ev), .srq_gen(srq_gen), .spoll_read(spoll_read),
        .key_local(key_local), .key_any(key_any), .rd_data(rd_data), .esb(esb), .osb(osb),
        .remote_indicator(remote_indicator), .talk_indicator(talk_indicator),
        .listener_indicator(listener_indicator), .srq_indicator(srq_indicator),
        .key_accept(key_accept), .restore_display(restore_display));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // one-cycle pulses are counted here so no test can miss them
    always @(posedge clk) begin
        if (key_accept === 1'b1) acc_cnt <= acc_cnt + 16'h1;
        if (restore_display === 1'b1) rst_cnt <= rst_cnt + 16'h1;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    task automatic rd(input gsr_reg_t s, input logic [15:0] exp);
        ctrl_inst.do_cmd(1'b0, 1'b1, s, 16'h0000);
        #1 check(rd_data, exp);
    endtask : rd
    task automatic wr(input gsr_reg_t s, input logic [15:0] d);
        ctrl_inst.do_cmd(1'b1, 1'b0, s, d);
    endtask : wr
    task automatic std_pulse(input logic [15:0] v, input logic q);
        @(posedge clk);
        std_event_in     <= v;
        empty_queue_read <= q;
        @(posedge clk);
        std_event_in     <= 16'h0000;
        empty_queue_read <= 1'b0;
    endtask : std_pulse
    task automatic key(input logic l, input logic a);
        @(posedge clk);
        key_local <= l;
        key_any   <= a;
        @(posedge clk);
        key_local <= 1'b0;
        key_any   <= 1'b0;
    endtask : key
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(GSR_REG_SEL, 16'h0000);
        rd(GSR_REG_SEM, 16'h0000);
        rd(GSR_REG_RISE, 16'hFFFF);
        rd(gsr_reg_t'(3'h7), 16'h0000);
        rd(GSR_REG_FALL, 16'h0000);
        rd(GSR_REG_OPEV, 16'h0000);
        $display("test reset values done");
    endtask : t_reset
    task automatic t_std();
        std_pulse(16'h0000, 1'b1);
        settle();
        rd(GSR_REG_SEL, 16'h0004);
        rd(GSR_REG_SEL, 16'h0000);
        wr(GSR_REG_SEL, 16'hFFFF);
        rd(GSR_REG_SEL, 16'h0000);
        wr(GSR_REG_SEM, 16'h0010);
        rd(GSR_REG_SEM, 16'h0010);
        rd(GSR_REG_SEM, 16'h0010);
        std_pulse(16'h0020, 1'b0);
        settle();
        check(esb, 16'h0000);
        std_pulse(16'h0010, 1'b0);
        settle();
        check(esb, 16'h0001);
        ctrl_inst.misc(1'b1, 1'b0, 1'b0);
        settle();
        check(esb, 16'h0000);
        rd(GSR_REG_SEL, 16'h0000);
        wr(GSR_REG_SEM, 16'h0000);
        rd(GSR_REG_SEM, 16'h0000);
        $display("test standard events done");
    endtask : t_std
    task automatic t_same_cycle();
        std_pulse(16'h0001, 1'b0);
        settle();
        fork
            ctrl_inst.do_cmd(1'b0, 1'b1, GSR_REG_SEL, 16'h0000);
            std_pulse(16'h0002, 1'b0);
        join
        #1 check(rd_data, 16'h0001);
        rd(GSR_REG_SEL, 16'h0002);
        $display("test read against new event done");
    endtask : t_same_cycle
    task automatic t_op();
        @(posedge clk) idle <= 1'b1;
        settle();
        rd(GSR_REG_COND, 16'h0400);
        rd(GSR_REG_OPEV, 16'h0400);
        rd(GSR_REG_OPEV, 16'h0000);
        wr(GSR_REG_FALL, 16'h0060);
        wr(GSR_REG_RISE, 16'h0000);
        rd(GSR_REG_FALL, 16'h0060);
        rd(GSR_REG_RISE, 16'h0000);
        @(posedge clk) wait_trig <= 1'b1;
        settle();
        rd(GSR_REG_COND, 16'h0420);
        rd(GSR_REG_OPEV, 16'h0000);
        @(posedge clk) wait_trig <= 1'b0;
        settle();
        rd(GSR_REG_OPEV, 16'h0020);
        wr(GSR_REG_RISE, 16'h0040);
        wr(GSR_REG_OPEN, 16'h0040);
        @(posedge clk) wait_arm <= 1'b1;
        settle();
        check(osb, 16'h0001);
        rd(GSR_REG_COND, 16'h0440);
        @(posedge clk) wait_arm <= 1'b0;
        settle();
        rd(GSR_REG_OPEV, 16'h0040);
        settle();
        check(osb, 16'h0000);
        ctrl_inst.misc(1'b0, 1'b1, 1'b0);
        rd(GSR_REG_RISE, 16'hFFFF);
        rd(GSR_REG_FALL, 16'h0000);
        rd(GSR_REG_OPEN, 16'h0000);
        @(posedge clk) other_cond <= 16'h8461;
        settle();
        rd(GSR_REG_COND, 16'h8401);
        ctrl_inst.misc(1'b1, 1'b0, 1'b0);
        rd(GSR_REG_OPEV, 16'h0000);
        $display("test operation events done");
    endtask : t_op
    task automatic t_iface();
        ctrl_inst.ren(1'b1);
        settle();
        check(remote_indicator, 16'h0000);
        ctrl_inst.bus(7'h20);
        settle();
        check({talk_indicator, listener_indicator, remote_indicator}, 16'h0003);
        key(1'b0, 1'b1);
        settle();
        check(acc_cnt, 16'h0000);
        ctrl_inst.bus(7'h40);
        settle();
        check({talk_indicator, listener_indicator}, 16'h0002);
        ctrl_inst.bus(7'h10);
        ctrl_inst.bus(7'h20);
        settle();
        check({talk_indicator, listener_indicator}, 16'h0001);
        ctrl_inst.bus(7'h08);
        settle();
        check(listener_indicator, 16'h0000);
        ctrl_inst.bus(7'h40);
        ctrl_inst.bus(7'h04);
        settle();
        check(talk_indicator, 16'h0000);
        ctrl_inst.bus(7'h20);
        ctrl_inst.bus(7'h04);
        settle();
        check(listener_indicator, 16'h0000);
        key(1'b1, 1'b0);
        settle();
        check({remote_indicator, rst_cnt[1:0]}, 16'h0001);
        key(1'b0, 1'b1);
        settle();
        check(acc_cnt, 16'h0001);
        ctrl_inst.bus(7'h20);
        ctrl_inst.bus(7'h02);
        key(1'b1, 1'b0);
        settle();
        check({remote_indicator, rst_cnt[1:0]}, 16'h0005);
        ctrl_inst.bus(7'h01);
        settle();
        check(remote_indicator, 16'h0000);
        ctrl_inst.bus(7'h22);
        settle();
        check(remote_indicator, 16'h0001);
        key(1'b1, 1'b0);
        settle();
        check({remote_indicator, rst_cnt[1:0]}, 16'h0005);
        ctrl_inst.ren(1'b0);
        settle();
        check(remote_indicator, 16'h0000);
        ctrl_inst.bus(7'h20);
        settle();
        check(remote_indicator, 16'h0000);
        @(posedge clk) srq_gen <= 1'b1;
        @(posedge clk) srq_gen <= 1'b0;
        repeat (10) settle();
        check(srq_indicator, 16'h0001);
        ctrl_inst.misc(1'b0, 1'b0, 1'b1);
        settle();
        check(srq_indicator, 16'h0000);
        $display("test interface state done");
    endtask : t_iface
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        std_event_in     = 16'h0000;
        empty_queue_read = 1'b0;
        idle             = 1'b0;
        wait_trig        = 1'b0;
        wait_arm         = 1'b0;
        other_cond       = 16'h0000;
        srq_gen          = 1'b0;
        key_local        = 1'b0;
        key_any          = 1'b0;
        repeat (2) @(posedge clk);
        #1 check({esb, osb, remote_indicator, talk_indicator, listener_indicator, srq_indicator}, 16'h0000);
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_std();
        t_same_cycle();
        t_op();
        t_iface();
        finish_test();
    end
endmodule : testbench
`default_nettype wire
